// file: hw/mmr_readback_regs.sv
// AXI4-Lite read-only measurement bank of the motor controller
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "mmr_map.svh"
module mmr_readback_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Values from the motor-control algorithm
    input  wire logic        meas_valid,
    input  wire logic [31:0] supply_current_in,
    input  wire logic [31:0] phase_a_current_in,
    input  wire logic [31:0] phase_b_current_in,
    input  wire logic [31:0] phase_c_current_in,
    input  wire logic [1:0]  gain_code_in,
    input  wire logic [1:0]  range_code_in,
    input  wire logic [31:0] supply_voltage_in,
    input  wire logic        spinning_motor_detection,
    input  wire logic [31:0] phase_a_voltage_in,
    input  wire logic [31:0] phase_b_voltage_in,
    input  wire logic [31:0] phase_c_voltage_in,
    // AXI4-Lite slave
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef struct packed {
        mmr_pkg::mmr_live_type live;
        logic                  aw_done;
        logic                  w_done;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rpend;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  rcap;
        logic [31:0]           rlocal;
        logic                  rmapped;
    } mmr_state_type;

    mmr_state_type state;
    mmr_state_type next_state;

    logic [11:0] rd_idx;
    logic [11:0] wr_idx;
    logic [1:0]  cap_sel;
    logic [31:0] cap_rdata;
    logic        ar_take;
    logic        wr_hit;

    assign rd_idx = s_axi_araddr[`MMR_ADDR_W-1:`MMR_IDX_LSB];
    assign wr_idx = s_axi_awaddr[`MMR_ADDR_W-1:`MMR_IDX_LSB];
    assign ar_take = s_axi_arvalid && state.arready;

    always_comb begin
        case (rd_idx)
            `MMR_IDX_PHASE_A_VOLTAGE: cap_sel = 2'h0;
            `MMR_IDX_PHASE_B_VOLTAGE: cap_sel = 2'h1;
            `MMR_IDX_PHASE_C_VOLTAGE: cap_sel = 2'h2;
            default:                  cap_sel = 2'h3;
        endcase
    end

    mmr_phase_capture u_capture (
        .aclk                     (aclk),
        .aresetn                  (aresetn),
        .spinning_motor_detection (spinning_motor_detection),
        .sample_valid             (meas_valid),
        .phase_a_in               (phase_a_voltage_in),
        .phase_b_in               (phase_b_voltage_in),
        .phase_c_in               (phase_c_voltage_in),
        .sel                      (cap_sel),
        .rdata                    (cap_rdata)
    );

    always_comb begin
        wr_hit = 1'b0;
        case (wr_idx)
            `MMR_IDX_SUPPLY_CURRENT, `MMR_IDX_PHASE_A_CURRENT, `MMR_IDX_PHASE_B_CURRENT,
            `MMR_IDX_PHASE_C_CURRENT, `MMR_IDX_GAIN_CODE, `MMR_IDX_RANGE_CODE,
            `MMR_IDX_SUPPLY_VOLTAGE, `MMR_IDX_PHASE_A_VOLTAGE, `MMR_IDX_PHASE_B_VOLTAGE,
            `MMR_IDX_PHASE_C_VOLTAGE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        // Algorithm updates; software has no path into these fields
        if (meas_valid) begin
            next_state.live.supply_current  = supply_current_in;  // RQ1
            next_state.live.phase_a_current = phase_a_current_in; // RQ2
            next_state.live.phase_b_current = phase_b_current_in; // RQ2
            next_state.live.phase_c_current = phase_c_current_in; // RQ2
            next_state.live.gain_code  = {14'h0000, gain_code_in};  // RQ3
            next_state.live.range_code = (range_code_in == 2'h3) ? state.live.range_code
                                       : {14'h0000, range_code_in}; // RQ4
            next_state.live.supply_voltage = supply_voltage_in; // RQ5
        end

        // Write channel: accepted and answered, data dropped
        next_state.awready = !state.aw_done && !state.bvalid;
        next_state.wready  = !state.w_done && !state.bvalid;
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_done = 1'b1;
            next_state.awready = 1'b0;
            next_state.bresp = wr_hit ? `MMR_RESP_SLVERR : `MMR_RESP_DECERR; // RQ8
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_done = 1'b1;
            next_state.wready = 1'b0;
        end
        if (next_state.aw_done && next_state.w_done && !state.bvalid) begin
            next_state.bvalid  = 1'b1;
            next_state.aw_done = 1'b0;
            next_state.w_done  = 1'b0;
            next_state.awready = 1'b0;
            next_state.wready  = 1'b0;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Read channel: decode, then merge with captured phase voltages
        next_state.arready = !state.rpend && !state.rvalid && !ar_take;
        if (ar_take) begin
            next_state.rpend = 1'b1;
            next_state.rcap = (cap_sel != 2'h3);
            next_state.rmapped = 1'b1;
            case (rd_idx)
                `MMR_IDX_SUPPLY_CURRENT:  next_state.rlocal = state.live.supply_current;
                `MMR_IDX_PHASE_A_CURRENT: next_state.rlocal = state.live.phase_a_current;
                `MMR_IDX_PHASE_B_CURRENT: next_state.rlocal = state.live.phase_b_current;
                `MMR_IDX_PHASE_C_CURRENT: next_state.rlocal = state.live.phase_c_current;
                `MMR_IDX_GAIN_CODE:       next_state.rlocal = {16'h0000, state.live.gain_code};
                `MMR_IDX_RANGE_CODE:      next_state.rlocal = {16'h0000, state.live.range_code};
                `MMR_IDX_SUPPLY_VOLTAGE:  next_state.rlocal = state.live.supply_voltage;
                `MMR_IDX_PHASE_A_VOLTAGE, `MMR_IDX_PHASE_B_VOLTAGE,
                `MMR_IDX_PHASE_C_VOLTAGE: next_state.rlocal = `MMR_WORD_RESET;
                default: begin
                    next_state.rlocal  = `MMR_WORD_RESET;
                    next_state.rmapped = 1'b0;
                end
            endcase
        end
        if (state.rpend) begin
            next_state.rpend  = 1'b0;
            next_state.rvalid = 1'b1;
            next_state.rdata  = state.rcap ? cap_rdata : state.rlocal; // RQ6
            next_state.rresp  = state.rmapped ? `MMR_RESP_OKAY : `MMR_RESP_DECERR;
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid  = 1'b0;
            next_state.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.live.gain_code  <= `MMR_CODE_RESET; // RQ7
            state.live.range_code <= `MMR_CODE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = state.awready;
    assign s_axi_wready  = state.wready;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;

    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    sequence s_read_answer;
        ##2 s_axi_rvalid;
    endsequence

    a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_taken |-> s_read_answer)
        else $error("read answer not two cycles after address");
    a_supply_current: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
        meas_valid |=> state.live.supply_current == $past(supply_current_in))
        else $error("supply current not loaded");
    a_phase_current: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        meas_valid |=> state.live.phase_c_current == $past(phase_c_current_in))
        else $error("phase current not loaded");
    a_gain_upper: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        state.live.gain_code[15:2] == 14'h0000)
        else $error("gain code outside 0..3");
    a_range_legal: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
        state.live.range_code <= `MMR_RANGE_60)
        else $error("range code outside 0..2");
    a_supply_voltage: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
        !meas_valid |=> $stable(state.live.supply_voltage))
        else $error("supply voltage changed without update");
    a_gain_reset: assert property (@(posedge aclk) // RQ7
        !aresetn |=> state.live.gain_code == `MMR_CODE_RESET)
        else $error("gain code not zero after reset");
    a_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        (s_axi_bvalid && !meas_valid) |=> $stable(state.live))
        else $error("write changed a measurement");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        s_axi_bvalid |-> s_axi_bresp != `MMR_RESP_OKAY)
        else $error("write answered okay");

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence

    sequence s_data_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_resp_taken;
        s_axi_bvalid && s_axi_bready;
    endsequence

    sequence s_rdata_taken;
        s_axi_rvalid && s_axi_rready;
    endsequence

    // Answers stand until the master takes them
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid)
        else $error("read answer dropped early");

    a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed while waiting");

    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write answer dropped early");

    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bresp))
        else $error("write response changed while waiting");

    a_read_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        s_read_taken |=> !s_axi_arready)
        else $error("read address ready after take");

    a_arready_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while answer pending");

    a_read_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rdata_taken |=> s_axi_arready && !s_axi_rvalid)
        else $error("read channel not reopened");

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_resp_taken |=> !s_axi_bvalid)
        else $error("write answer not withdrawn");

    a_write_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
        s_resp_taken |=> ##1 (s_axi_awready && s_axi_wready))
        else $error("write channels not reopened");

    a_write_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while answer pending");

    a_aw_once: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_taken |=> !s_axi_awready)
        else $error("write address ready after take");

    a_w_once: assert property (@(posedge aclk) disable iff (!aresetn)
        s_data_taken |=> !s_axi_wready)
        else $error("write data ready after take");

    a_gain_read: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        (s_read_taken ##0 (rd_idx == `MMR_IDX_GAIN_CODE)) |->
        ##2 (s_axi_rdata == {16'h0000, $past(state.live.gain_code, 2)}))
        else $error("gain code read wrong");

    a_range_read: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
        (s_read_taken ##0 (rd_idx == `MMR_IDX_RANGE_CODE)) |->
        ##2 (s_axi_rdata == {16'h0000, $past(state.live.range_code, 2)}))
        else $error("range code read wrong");

    a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> (s_axi_rresp == `MMR_RESP_OKAY || s_axi_rresp == `MMR_RESP_DECERR))
        else $error("read response code illegal");

    a_decerr_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && s_axi_rresp == `MMR_RESP_DECERR) |-> s_axi_rdata == `MMR_WORD_RESET)
        else $error("unmapped read returned data");

    a_phase_a_current: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        meas_valid |=> state.live.phase_a_current == $past(phase_a_current_in))
        else $error("phase a current not loaded");

    a_phase_b_current: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        meas_valid |=> state.live.phase_b_current == $past(phase_b_current_in))
        else $error("phase b current not loaded");

    a_gain_load: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        meas_valid |=> state.live.gain_code == {14'h0000, $past(gain_code_in)})
        else $error("gain code not loaded");

    a_range_keep: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
        (meas_valid && range_code_in == 2'h3) |=> $stable(state.live.range_code))
        else $error("undefined range code accepted");

    a_range_load: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
        (meas_valid && range_code_in != 2'h3) |=>
        state.live.range_code == {14'h0000, $past(range_code_in)})
        else $error("range code not loaded");

    a_current_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
        !meas_valid |=> $stable(state.live.supply_current))
        else $error("supply current changed without update");

    a_phase_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        !meas_valid |=> $stable(state.live.phase_a_current))
        else $error("phase current changed without update");

    a_gain_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        !meas_valid |=> $stable(state.live.gain_code))
        else $error("gain code changed without update");

    a_write_decerr: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        (s_write_taken ##0 !wr_hit) |=> s_axi_bresp == `MMR_RESP_DECERR)
        else $error("unmapped write not decode error");

    a_write_slverr: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        (s_write_taken ##0 wr_hit) |=> s_axi_bresp == `MMR_RESP_SLVERR)
        else $error("bank write not refused");
endmodule : mmr_readback_regs

// file: shared/mmr_map.svh
// Offsets, field positions, reset values, code tables and response codes of the measurement bank
// Operation
// [RQ1] Supply current: signed 32-bit, 2^27 scaled, gain-dependent
// [RQ2] Three phase currents: signed 32-bit, same scaling
// [RQ3] Current-sense gain code: 16-bit read-only, 0..3
// [RQ4] Voltage range code: 16-bit read-only, 0..2
// [RQ5] Supply voltage: 32-bit, times 60 over 2^27
// [RQ6] Phase voltages captured during spinning-motor detection
// [RQ7] Gain code register resets to zero
// [RQ8] Software writes to the bank are ignored
`ifndef MMR_MAP_SVH
`define MMR_MAP_SVH
// Printed offsets are not all multiples of four: these are indices
`define MMR_IDX_SUPPLY_CURRENT  12'h40e
`define MMR_IDX_PHASE_A_CURRENT 12'h43c
`define MMR_IDX_PHASE_B_CURRENT 12'h43e
`define MMR_IDX_PHASE_C_CURRENT 12'h440
`define MMR_IDX_GAIN_CODE       12'h450
`define MMR_IDX_RANGE_CODE      12'h458
`define MMR_IDX_SUPPLY_VOLTAGE  12'h45c
`define MMR_IDX_PHASE_A_VOLTAGE 12'h460
`define MMR_IDX_PHASE_B_VOLTAGE 12'h462
`define MMR_IDX_PHASE_C_VOLTAGE 12'h464
`define MMR_ADDR_W              14
`define MMR_IDX_LSB             2
`define MMR_WORD_RESET          32'h00000000
`define MMR_CODE_RESET          16'h0000
`define MMR_CODE_W              16
`define MMR_FRAC_BITS           27
`define MMR_GAIN_40             16'h0000
`define MMR_GAIN_20             16'h0001
`define MMR_GAIN_10             16'h0002
`define MMR_GAIN_5              16'h0003
`define MMR_RANGE_15            16'h0000
`define MMR_RANGE_30            16'h0001
`define MMR_RANGE_60            16'h0002
`define MMR_RESP_OKAY           2'h0
`define MMR_RESP_SLVERR         2'h2
`define MMR_RESP_DECERR         2'h3
`endif

// file: shared/mmr_pkg.sv
// Types of the measurement readback bank
package mmr_pkg;
    typedef enum logic [1:0] {
        mmr_idle_type_e = 2'h0,
        mmr_resp_type_e = 2'h1
    } mmr_phase_type;

    typedef struct packed {
        logic [31:0] supply_current;
        logic [31:0] phase_a_current;
        logic [31:0] phase_b_current;
        logic [31:0] phase_c_current;
        logic [15:0] gain_code;
        logic [15:0] range_code;
        logic [31:0] supply_voltage;
    } mmr_live_type;
endpackage : mmr_pkg

// file: hw/mmr_phase_capture.sv
// Phase voltage capture registers, loaded only during spinning-motor detection
`timescale 1ns/100ps
`include "mmr_map.svh"
module mmr_phase_capture (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        spinning_motor_detection,
    input  wire logic        sample_valid,
    input  wire logic [31:0] phase_a_in,
    input  wire logic [31:0] phase_b_in,
    input  wire logic [31:0] phase_c_in,
    input  wire logic [1:0]  sel,
    output logic      [31:0] rdata
);
    typedef struct packed {
        logic [31:0] va;
        logic [31:0] vb;
        logic [31:0] vc;
        logic [31:0] rdata;
    } mmr_cap_type;

    mmr_cap_type state;
    mmr_cap_type next_state;

    always_comb begin
        next_state = state;
        if (spinning_motor_detection && sample_valid) begin // RQ6
            next_state.va = phase_a_in;
            next_state.vb = phase_b_in;
            next_state.vc = phase_c_in;
        end
        case (sel)
            2'h0: next_state.rdata = state.va;
            2'h1: next_state.rdata = state.vb;
            2'h2: next_state.rdata = state.vc;
            default: next_state.rdata = `MMR_WORD_RESET;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;

    a_capture_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
        !(spinning_motor_detection && sample_valid) |=> $stable(state.va))
        else $error("phase voltage changed outside detection");
    a_capture_load: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
        (spinning_motor_detection && sample_valid) |=> state.vb == $past(phase_b_in))
        else $error("phase voltage not captured");
endmodule : mmr_phase_capture

// file: verification/test_mmr_readback_regs.sv
// Self-checking bench of the measurement readback bank over AXI4-Lite
`timescale 1ns/100ps
`include "mmr_map.svh"
module test_mmr_readback_regs;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        meas_valid = 1'b0;
    logic        spinning_motor_detection = 1'b0;
    logic [31:0] supply_current_in = 32'h0, phase_a_current_in = 32'h0;
    logic [31:0] phase_b_current_in = 32'h0, phase_c_current_in = 32'h0;
    logic [1:0]  gain_code_in = 2'h0, range_code_in = 2'h0;
    logic [31:0] supply_voltage_in = 32'h0, phase_a_voltage_in = 32'h0;
    logic [31:0] phase_b_voltage_in = 32'h0, phase_c_voltage_in = 32'h0;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          error_cnt = 0;
    int          comparisons = 0;
    logic [11:0] idx [10] = '{`MMR_IDX_SUPPLY_CURRENT, `MMR_IDX_PHASE_A_CURRENT,
        `MMR_IDX_PHASE_B_CURRENT, `MMR_IDX_PHASE_C_CURRENT, `MMR_IDX_GAIN_CODE,
        `MMR_IDX_RANGE_CODE, `MMR_IDX_SUPPLY_VOLTAGE, `MMR_IDX_PHASE_A_VOLTAGE,
        `MMR_IDX_PHASE_B_VOLTAGE, `MMR_IDX_PHASE_C_VOLTAGE};
    logic [15:0] gains [4] = '{`MMR_GAIN_40, `MMR_GAIN_20, `MMR_GAIN_10, `MMR_GAIN_5};
    logic [15:0] ranges [3] = '{`MMR_RANGE_15, `MMR_RANGE_30, `MMR_RANGE_60};
    logic [31:0] exp_v [10];

    mmr_readback_regs mmr_readback_regs_i (
        .aclk, .aresetn, .meas_valid, .supply_current_in, .phase_a_current_in,
        .phase_b_current_in, .phase_c_current_in, .gain_code_in, .range_code_in,
        .supply_voltage_in, .spinning_motor_detection, .phase_a_voltage_in,
        .phase_b_voltage_in, .phase_c_voltage_in, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    always #25 aclk = ~aclk;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic axi_read(input logic [11:0] i, input logic [31:0] ed, input logic [1:0] er);
        int n;
        int t;
        n = 0;
        t = 0;
        @(posedge aclk);
        s_axi_araddr  <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                t = n;
            end
        end while (!s_axi_rvalid);
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        check("rlatency", 32'h2, n - t);
        s_axi_rready  <= 1'b0;
    endtask : axi_read

    task automatic axi_write(input logic [11:0] i, input logic [31:0] d, input logic [1:0] er);
        int n;
        int ta;
        int tw;
        n = 0;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        s_axi_awaddr  <= {i, 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                ta = n;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                tw = n;
            end
        end while (!s_axi_bvalid);
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        check("blatency", 32'h1, n - ((ta > tw) ? ta : tw));
        s_axi_bready  <= 1'b0;
    endtask : axi_write

    // One load strobe, optionally inside the detection window
    task automatic load(input logic det);
        @(posedge aclk);
        spinning_motor_detection <= det;
        meas_valid               <= 1'b1;
        @(posedge aclk);
        spinning_motor_detection <= 1'b0;
        meas_valid               <= 1'b0;
    endtask : load

    task automatic check_all(input string name);
        for (int k = 0; k < 10; k++) axi_read(idx[k], exp_v[k], `MMR_RESP_OKAY);
        $display("test %s done", name);
    endtask : check_all

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (exp_v[k]) exp_v[k] = `MMR_WORD_RESET;
        check_all("reset_values");
        supply_current_in  <= 32'hf8000000;
        phase_a_current_in <= 32'h08000000;
        phase_b_current_in <= 32'hfc000001;
        phase_c_current_in <= 32'h80000000;
        gain_code_in       <= 2'h3;
        range_code_in      <= 2'h2;
        supply_voltage_in  <= 32'h7fffffff;
        phase_a_voltage_in <= 32'h12345678;
        phase_b_voltage_in <= 32'h9abcdef0;
        phase_c_voltage_in <= 32'h0badcafe;
        load(1'b1);
        exp_v = '{32'hf8000000, 32'h08000000, 32'hfc000001, 32'h80000000,
            {16'h0, `MMR_GAIN_5}, {16'h0, `MMR_RANGE_60}, 32'h7fffffff,
            32'h12345678, 32'h9abcdef0, 32'h0badcafe};
        check_all("load_in_detection");
        phase_a_voltage_in <= 32'h0;
        phase_b_voltage_in <= 32'hffffffff;
        phase_c_voltage_in <= 32'h55555555;
        supply_voltage_in  <= 32'h00000001;
        load(1'b0);
        exp_v[6] = 32'h00000001;
        check_all("no_capture_outside_detection");
        for (int g = 0; g < 4; g++) begin
            gain_code_in <= g[1:0];
            load(1'b0);
            axi_read(`MMR_IDX_GAIN_CODE, {16'h0, gains[g]}, `MMR_RESP_OKAY);
        end
        for (int r = 0; r < 3; r++) begin
            range_code_in <= r[1:0];
            load(1'b0);
            axi_read(`MMR_IDX_RANGE_CODE, {16'h0, ranges[r]}, `MMR_RESP_OKAY);
        end
        // Undefined range code keeps the previous setting
        range_code_in <= 2'h3;
        load(1'b0);
        axi_read(`MMR_IDX_RANGE_CODE, {16'h0, ranges[2]}, `MMR_RESP_OKAY);
        $display("test code_tables done");
        axi_write(`MMR_IDX_GAIN_CODE, 32'hffffffff, `MMR_RESP_SLVERR);
        axi_write(`MMR_IDX_SUPPLY_CURRENT, 32'h0, `MMR_RESP_SLVERR);
        axi_read(`MMR_IDX_GAIN_CODE, {16'h0, gains[3]}, `MMR_RESP_OKAY);
        axi_read(`MMR_IDX_SUPPLY_CURRENT, 32'hf8000000, `MMR_RESP_OKAY);
        axi_write(12'h442, 32'h1, `MMR_RESP_DECERR);
        axi_read(12'h442, 32'h0, `MMR_RESP_DECERR);
        $display("test writes_refused done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (exp_v[k]) exp_v[k] = `MMR_WORD_RESET;
        check_all("mid_run_reset");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end
endmodule : test_mmr_readback_regs
